/* ata_host_model.sv */
// host side model: feeds write words and drains threshold words
`timescale 1ns/1ps
module ata_host_model (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        ce,
    input  wire logic        slow,
    // write words toward the device
    input  wire logic        din_ready_q,
    output logic             din_valid,
    output logic [15:0]      din,
    // threshold words from the device
    input  wire logic        dout_valid_q,
    input  wire logic [15:0] dout_q,
    output logic             dout_ready,
    // progress seen by the bench
    output logic [16:0]      sent,
    output logic [16:0]      got,
    output logic [15:0]      first_rd,
    output logic [15:0]      last_rd
);
    logic [3:0] ph;
    logic       tk;
    logic       want;
    assign tk   = ce && din_valid && din_ready_q;
    assign want = din_ready_q && !(slow && ph[1]);
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            {din_valid, dout_ready, sent, got, ph} <= '0;
            {din, first_rd, last_rd} <= '0;
        end
        else
        begin
            ph <= ph + 4'h1;
            // a word stays put until the edge that takes it
            if (tk || !din_valid)
            begin
                din_valid <= want;
                din       <= want ? sent[15:0] + 16'(tk) : ~din;
            end
            if (tk)
                sent <= sent + 17'h1;
            // a slow host drops dout_ready on every other clock
            dout_ready <= !(slow && ph[0]);
            if (ce && dout_valid_q && dout_ready)
            begin
                got     <= got + 17'h1;
                last_rd <= dout_q;
                if (got == 17'h0)
                    first_rd <= dout_q;
            end
        end
    end
endmodule : ata_host_model

/* ata_smart_write_command_handler_tb_top.sv */
// bench for the smart, standby and write command handler
`timescale 1ns/1ps
module ata_smart_write_command_handler_tb_top;
    typedef struct {logic [7:0] code, feat, sect; logic [3:0] f;} row_t;
    typedef struct {logic [7:0] code; logic [15:0] sect;
        logic [7:0] mult; logic [2:0] f; int secs, mid;} wrow_t;
    logic        mclk, nrst, ce, cmd_valid, dma_mode_ok, defect_pred, slow;
    logic        nv_smart_en, nv_autosave, flush_done, din_valid;
    logic        busy_q, irq_q, abort_q, standby_q, din_ready_q, wr_valid_q;
    logic        dout_valid_q, smart_en_q, autosave_q, auto_coll_q, nv_wr_q;
    logic        save_attr_q, offline_go_q, flush_req_q, dout_ready, ce_q;
    logic [7:0]  cmd_code, feat, mult_cnt, cyl_lo_q, cyl_hi_q;
    logic [15:0] sect_cnt, din, dout_q, wr_data_q, first_rd, last_rd, e;
    logic [16:0] sent, got, wr_n, w0;
    logic [3:0]  fl_n;
    logic [2:0]  pl, px;
    int          fail_count = 0, comparisons = 0, fl_tot = 0, n, mid;
    // flags: defect, abort, smart on, auto collect
    row_t rows [20] = '{
        '{8'hb0, 8'hda, 8'h00, 4'h4}, '{8'hb0, 8'hd9, 8'h00, 4'h4},
        '{8'hb0, 8'hd8, 8'h00, 4'h2}, '{8'hb0, 8'hd8, 8'h00, 4'h2},
        '{8'hb0, 8'hda, 8'h00, 4'h2}, '{8'hb0, 8'hda, 8'h00, 4'ha},
        '{8'hb0, 8'hd5, 8'h00, 4'h6}, '{8'hb0, 8'hd2, 8'hf1, 4'h2},
        '{8'hb0, 8'hd2, 8'h55, 4'h6}, '{8'hb0, 8'hdb, 8'h00, 4'h2},
        '{8'hb0, 8'hdb, 8'hf8, 4'h3}, '{8'hb0, 8'hdb, 8'h55, 4'h3},
        '{8'hb0, 8'hd3, 8'h00, 4'h3}, '{8'hb0, 8'hd4, 8'h00, 4'h3},
        '{8'he2, 8'h00, 8'h00, 4'h3}, '{8'he0, 8'h00, 8'h00, 4'h3},
        '{8'hca, 8'h00, 8'h01, 4'h7}, '{8'hc5, 8'h00, 8'h01, 4'h7},
        '{8'h00, 8'h00, 8'h00, 4'h7}, '{8'hb0, 8'hd9, 8'h00, 4'h0}};
    // flags: dma mode set, slow host, commit to media
    wrow_t wrows [11] = '{
        '{8'he8, 16'h0000, 8'h00, 3'h0, 1, 0},
        '{8'h30, 16'h0000, 8'h00, 3'h0, 256, 255},
        '{8'h31, 16'h0101, 8'h00, 3'h0, 1, 0},
        '{8'h34, 16'h0002, 8'h00, 3'h2, 2, 1},
        '{8'hc5, 16'h0004, 8'h02, 3'h0, 4, 1},
        '{8'h39, 16'h0003, 8'h02, 3'h0, 3, 1},
        '{8'hce, 16'h0003, 8'h02, 3'h1, 3, 1},
        '{8'hca, 16'h0001, 8'h00, 3'h4, 1, 0},
        '{8'h35, 16'h0002, 8'h00, 3'h6, 2, 0},
        '{8'h3d, 16'h0001, 8'h00, 3'h5, 1, 0},
        '{8'h61, 16'h0002, 8'h00, 3'h0, 2, 0}};

    smart_wr_ctrl i_dut (.mclk, .nrst, .ce, .cmd_valid, .cmd_code, .feat,
        .sect_cnt, .mult_cnt, .dma_mode_ok, .defect_pred, .nv_smart_en,
        .nv_autosave, .flush_done, .din_valid, .din, .dout_ready, .busy_q,
        .irq_q, .abort_q, .cyl_lo_q, .cyl_hi_q, .standby_q, .din_ready_q,
        .wr_valid_q, .wr_data_q, .dout_valid_q, .dout_q, .smart_en_q,
        .autosave_q, .auto_coll_q, .nv_wr_q, .save_attr_q, .offline_go_q,
        .flush_req_q);
    ata_host_model i_host (.mclk, .nrst, .ce, .slow, .din_ready_q,
        .din_valid, .din, .dout_valid_q, .dout_q, .dout_ready, .sent, .got,
        .first_rd, .last_rd);

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic chk(string nm, logic [15:0] ex, logic [15:0] g);
        comparisons++;
        if (g !== ex)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, g);
        end
    endtask : chk

    task automatic chkn(string nm, int ex, int g);
        comparisons++;
        if (g != ex)
        begin
            fail_count++;
            $display("[FAIL] %s expected %0d seen %0d", nm, ex, g);
        end
    endtask : chkn

    task automatic stop_test;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    task automatic issue(logic [7:0] c, logic [7:0] f, logic [15:0] s);
        @(posedge mclk);
        #1;
        cmd_valid = 1'b1;
        cmd_code  = c;
        feat      = f;
        sect_cnt  = s;
        @(posedge mclk);
        #1;
        cmd_valid = 1'b0;
    endtask : issue

    task automatic do_cmd(logic [7:0] c, logic [7:0] f, logic [15:0] s);
        issue(c, f, s);
        pl  = {nv_wr_q, save_attr_q, offline_go_q};
        n   = 1;
        mid = 0;
        chk("busy", 16'h1, 16'(busy_q));
        while (!(irq_q === 1'b1 && busy_q === 1'b0) && n < 80000)
        begin
            mid += int'(irq_q === 1'b1);
            @(posedge mclk);
            #1;
            n++;
        end
    endtask : do_cmd

    // echo order of written words and the media commit responder
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_n <= '0;
            fl_n <= '0;
            ce_q <= 1'b0;
        end
        else
        begin
            ce_q <= ce;
            if (wr_valid_q === 1'b1 && ce_q)
            begin
                chk("wr_data", wr_n[15:0], wr_data_q);
                wr_n <= wr_n + 17'h1;
            end
            fl_n       <= (flush_req_q === 1'b1) ? fl_n + 4'h1 : 4'h0;
            fl_tot     <= fl_tot + int'(flush_req_q === 1'b1);
            flush_done <= #1 (fl_n == 4'h8);
        end
    end

    initial
    begin
        #2400000;
        fail_count++;
        $display("[FAIL] watchdog expected finish seen hang");
        stop_test();
    end

    initial
    begin
        {nrst, cmd_valid, dma_mode_ok, defect_pred, slow} = '0;
        {nv_smart_en, nv_autosave, flush_done} = '0;
        {cmd_code, feat, mult_cnt, sect_cnt} = '0;
        ce = 1'b1;
        repeat (4) @(posedge mclk);
        #1 nrst = 1'b1;
        repeat (2) @(posedge mclk);
        foreach (rows[i])
        begin
            defect_pred = rows[i].f[3];
            e = rows[i].f[3] ? 16'h2cf4 : 16'hc24f;
            do_cmd(rows[i].code, rows[i].feat, {8'h00, rows[i].sect});
            chkn("latency", 2, n);
            chk("abort", 16'(rows[i].f[2]), 16'(abort_q));
            chk("smart_en", 16'(rows[i].f[1]), 16'(smart_en_q));
            chk("auto_coll", 16'(rows[i].f[0]), 16'(auto_coll_q));
            px = {rows[i].feat inside {8'hd2, 8'hd9},
                  rows[i].feat == 8'hd3, rows[i].feat == 8'hd4};
            if (rows[i].feat == 8'hd8 && !(i > 0 && rows[i-1].f[1]))
                px[2] = 1'b1;
            if (rows[i].code != 8'hb0 || rows[i].f[2])
                px = 3'h0;
            chk("pulses", 16'(px), 16'(pl));
            if (rows[i].feat == 8'hda && !rows[i].f[2])
                chk("cyl", e, {cyl_hi_q, cyl_lo_q});
            if (rows[i].code inside {8'he2, 8'he0})
                chk("standby", 16'h1, 16'(standby_q));
        end
        chk("autosave", 16'h1, 16'(autosave_q));
        foreach (wrows[i])
        begin
            w0          = wr_n;
            mult_cnt    = wrows[i].mult;
            dma_mode_ok = wrows[i].f[2];
            slow        = wrows[i].f[1];
            fl_tot      = 0;
            fork
                do_cmd(wrows[i].code, 8'h00, wrows[i].sect);
                if (slow)
                begin
                    repeat (50) @(posedge mclk);
                    #1 ce = 1'b0;
                    repeat (4) @(posedge mclk);
                    #1 ce = 1'b1;
                end
            join
            chkn("words", wrows[i].secs * 256, int'(wr_n - w0));
            chkn("mid_irq", wrows[i].mid, mid);
            chkn("flush", int'(wrows[i].f[0]), int'(fl_tot > 8));
            chk("standby", 16'h0, 16'(standby_q));
            if (wrows[i].code == 8'he8)
                chkn("e8_cycles", 259, n);
        end
        slow = 1'b0;
        issue(8'h30, 8'h00, 16'h0005);
        repeat (100) @(posedge mclk);
        #1;
        nrst        = 1'b0;
        nv_smart_en = 1'b1;
        nv_autosave = 1'b1;
        #1;
        chk("reset_out", 16'h0, 16'({din_ready_q, busy_q, wr_valid_q}));
        repeat (2) @(posedge mclk);
        #1 nrst = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        chk("smart_en", 16'h1, 16'(smart_en_q));
        chk("autosave", 16'h1, 16'(autosave_q));
        slow = 1'b1;
        do_cmd(8'hb0, 8'hd1, 16'h0000);
        chkn("thr_words", 256, int'(got));
        chk("thr_first", 16'h0001, first_rd);
        chk("thr_last", 16'hff00, last_rd);
        stop_test();
    end
endmodule : ata_smart_write_command_handler_tb_top

/* smart_wr_ctrl.sv */
// smart subcommands, standby and write command execution
// Operation
// - smart subcommand from features, unknown aborts
// - healthy status loads 4fh and c2h
// - predicted defect loads f4h and 2ch
// - auto offline: f8h enables, 00h disables
// - smart disabled aborts all but enable
// - smart enable state kept non-volatile
// - enable while enabled changes nothing
// - disable clears smart enable and stops auto collection
// - autosave setting switchable and non-volatile
// - threshold read returns 512 bytes
// - save attributes writes modified values out
// - offline immediate starts collection, no data
// - e2h busy, standby, unbusy, interrupt
// - e0h busy, standby, unbusy, interrupt
// - e8h takes one 512-byte block
// - cah/35h dma writes need mode set
// - 3dh commits to media before completion
// - multiple writes interrupt per block
// - ceh commits to media before completion
// - 30h/31h count 00h means 256
// - 34h zero count means 65536
// - 61h queued write moves host data in
`timescale 1ns/1ps
`include "smart_wr_defines.svh"
module smart_wr_ctrl
    import smart_wr_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        ce,
    // command from the register file
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [7:0]  feat,
    input  wire logic [15:0] sect_cnt,
    input  wire logic [7:0]  mult_cnt,
    input  wire logic        dma_mode_ok,
    input  wire logic        defect_pred,
    // stored settings and media
    input  wire logic        nv_smart_en,
    input  wire logic        nv_autosave,
    input  wire logic        flush_done,
    // host write data
    input  wire logic        din_valid,
    input  wire logic [15:0] din,
    input  wire logic        dout_ready,
    // status back to the host
    output logic             busy_q,
    output logic             irq_q,
    output logic             abort_q,
    output logic [7:0]       cyl_lo_q,
    output logic [7:0]       cyl_hi_q,
    output logic             standby_q,
    // data paths
    output logic             din_ready_q,
    output logic             wr_valid_q,
    output logic [15:0]      wr_data_q,
    output logic             dout_valid_q,
    output logic [15:0]      dout_q,
    // smart and media control
    output logic             smart_en_q,
    output logic             autosave_q,
    output logic             auto_coll_q,
    output logic             nv_wr_q,
    output logic             save_attr_q,
    output logic             offline_go_q,
    output logic             flush_req_q
);
    st_t         st_q, st_d;
    logic        load_q, load_d;
    logic        busy_d, irq_d, abort_d, stby_d, drdy_d, wrv_d;
    logic        dov_d, sen_d, asv_d, aoff_q, aoff_d, acol_d;
    logic        nvw_d, sav_d, off_d, flr_d, fua_q, fua_d;
    logic [7:0]  clo_d, chi_d, word_q, word_d, blk_q, blk_d;
    logic [7:0]  per_q, per_d;
    logic [16:0] left_q, left_d;
    logic [15:0] wdat_d, dout_d;
    logic [15:0] wbuf [0:255];

    // threshold block: revision word, zero thresholds, checksum byte
    function automatic logic [15:0] thr_word(input logic [7:0] a);
        thr_word = 16'h0000;
        if (a == 8'h00)
            thr_word = `THR_REV;
        else if (a == `LAST_WORD)
            thr_word = `THR_LAST;
    endfunction : thr_word

    always_comb
    begin
        st_d = st_q; load_d = load_q; busy_d = busy_q; irq_d = 1'b0;
        abort_d = abort_q; clo_d = cyl_lo_q; chi_d = cyl_hi_q;
        stby_d = standby_q; drdy_d = din_ready_q; wrv_d = 1'b0;
        wdat_d = wr_data_q; dov_d = dout_valid_q; dout_d = dout_q;
        sen_d = smart_en_q; asv_d = autosave_q; aoff_d = aoff_q;
        nvw_d = 1'b0; sav_d = 1'b0; off_d = 1'b0; flr_d = flush_req_q;
        fua_d = fua_q; word_d = word_q; blk_d = blk_q; per_d = per_q;
        left_d = left_q;
        acol_d = aoff_q & smart_en_q;
        case (st_q)
            ST_IDLE:
            begin
                if (!load_q)
                begin
                    load_d = 1'b1;
                    sen_d  = nv_smart_en;
                    asv_d  = nv_autosave;
                end
                else if (cmd_valid)
                begin
                    busy_d = 1'b1; abort_d = 1'b0; st_d = ST_DONE;
                    word_d = 8'h00; fua_d = 1'b0; per_d = 8'h01;
                    left_d = {1'b0, sect_cnt};
                    case (cmd_code)
                        `CMD_SMART:
                            if (!smart_en_q && feat != `SUB_ENABLE)
                                abort_d = 1'b1;
                            else
                                case (feat)
                                    `SUB_THR_READ:
                                    begin
                                        st_d = ST_DOUT;
                                        dov_d = 1'b1;
                                        dout_d = thr_word(8'h00);
                                    end
                                    `SUB_AUTOSAVE:
                                        if (sect_cnt[7:0] == `AUTOSAVE_ON
                                            || sect_cnt[7:0]
                                               == `AUTOSAVE_OFF)
                                        begin
                                            asv_d = sect_cnt[7:0]
                                                    == `AUTOSAVE_ON;
                                            nvw_d = 1'b1;
                                        end
                                        else
                                            abort_d = 1'b1;
                                    `SUB_SAVE_ATTR: sav_d = 1'b1;
                                    `SUB_OFFLINE:   off_d = 1'b1;
                                    `SUB_ENABLE:
                                        if (!smart_en_q)
                                        begin
                                            sen_d = 1'b1;
                                            nvw_d = 1'b1;
                                        end
                                    `SUB_DISABLE:
                                    begin
                                        sen_d = 1'b0;
                                        nvw_d = 1'b1;
                                    end
                                    `SUB_STATUS:
                                        if (defect_pred)
                                        begin
                                            clo_d = `RS_BAD_LO;
                                            chi_d = `RS_BAD_HI;
                                        end
                                        else
                                        begin
                                            clo_d = `RS_OK_LO;
                                            chi_d = `RS_OK_HI;
                                        end
                                    `SUB_AUTO_OFF:
                                        if (sect_cnt[7:0] == `AUTO_OFF_ON)
                                            aoff_d = 1'b1;
                                        else if (sect_cnt[7:0]
                                                 == `AUTO_OFF_OFF)
                                            aoff_d = 1'b0;
                                    default: abort_d = 1'b1;
                                endcase
                        `CMD_STANDBY, `CMD_STBY_IMM:
                            stby_d = 1'b1;
                        `CMD_WR_BUF:
                        begin
                            left_d = 17'd1;
                            per_d = 8'h01; st_d = ST_DIN;
                        end
                        `CMD_WR_DMA, `CMD_WR_DMA_X, `CMD_WR_DMA_FUA,
                        `CMD_WR_FPDMA:
                            if (!dma_mode_ok && cmd_code != `CMD_WR_FPDMA)
                                abort_d = 1'b1;
                            else
                            begin
                                st_d = ST_DIN; per_d = 8'h00;
                                fua_d = cmd_code == `CMD_WR_DMA_FUA;
                                if (cmd_code == `CMD_WR_DMA)
                                    left_d = {9'd0, sect_cnt[7:0]};
                            end
                        `CMD_WR_MUL, `CMD_WR_MUL_X, `CMD_WR_MUL_FUA:
                            if (mult_cnt == 8'h00)
                                abort_d = 1'b1;
                            else
                            begin
                                st_d = ST_DIN; per_d = mult_cnt;
                                fua_d = cmd_code == `CMD_WR_MUL_FUA;
                                if (cmd_code == `CMD_WR_MUL)
                                    left_d = {9'd0, sect_cnt[7:0]};
                            end
                        `CMD_WR_SEC, `CMD_WR_SEC_NR:
                        begin
                            st_d = ST_DIN;
                            left_d = {9'd0, sect_cnt[7:0]};
                        end
                        `CMD_WR_SEC_X: st_d = ST_DIN;
                        default: abort_d = 1'b1;
                    endcase
                    if (st_d == ST_DIN)
                    begin
                        stby_d = 1'b0; drdy_d = 1'b1; blk_d = 8'h00;
                        if (left_d == 17'd0)
                            left_d = (cmd_code == `CMD_WR_SEC
                                      || cmd_code == `CMD_WR_SEC_NR
                                      || cmd_code == `CMD_WR_DMA
                                      || cmd_code == `CMD_WR_MUL)
                                     ? `SEC_256 : `SEC_65536;
                    end
                end
            end
            ST_DIN:
                if (din_valid && din_ready_q)
                begin
                    wrv_d = 1'b1; wdat_d = din;
                    word_d = word_q + 8'h01;
                    if (word_q == `LAST_WORD)
                    begin
                        left_d = left_q - 17'd1;
                        blk_d = blk_q + 8'h01;
                        if (per_q != 8'h00 && blk_d == per_q
                            && left_q != 17'd1)
                        begin
                            irq_d = 1'b1;
                            blk_d = 8'h00;
                        end
                        if (left_q == 17'd1)
                        begin
                            drdy_d = 1'b0;
                            st_d = fua_q ? ST_FLUSH : ST_DONE;
                            flr_d = fua_q;
                        end
                    end
                end
            ST_DOUT:
                if (dout_ready)
                begin
                    word_d = word_q + 8'h01;
                    dout_d = thr_word(word_d);
                    if (word_q == `LAST_WORD)
                    begin
                        dov_d = 1'b0;
                        st_d = ST_DONE;
                    end
                end
            ST_FLUSH:
                if (flush_done)
                begin
                    flr_d = 1'b0;
                    st_d = ST_DONE;
                end
            ST_DONE:
            begin
                busy_d = 1'b0;
                irq_d = 1'b1;
                st_d = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
        if (ce && st_q == ST_DIN && din_valid && din_ready_q)
            wbuf[word_q] <= din;

    always_ff @(posedge mclk or negedge nrst)
        if (!nrst)
        begin
            st_q <= ST_IDLE; load_q <= 1'b0; busy_q <= 1'b0;
            irq_q <= 1'b0; abort_q <= 1'b0; cyl_lo_q <= 8'h00;
            cyl_hi_q <= 8'h00; standby_q <= 1'b0; din_ready_q <= 1'b0;
            wr_valid_q <= 1'b0; wr_data_q <= 16'h0000;
            dout_valid_q <= 1'b0; dout_q <= 16'h0000;
            smart_en_q <= 1'b0; autosave_q <= 1'b0; aoff_q <= 1'b0;
            auto_coll_q <= 1'b0; nv_wr_q <= 1'b0; save_attr_q <= 1'b0;
            offline_go_q <= 1'b0; flush_req_q <= 1'b0; fua_q <= 1'b0;
            word_q <= 8'h00; blk_q <= 8'h00; per_q <= 8'h00;
            left_q <= 17'd0;
        end
        else if (ce)
        begin
            st_q <= st_d; load_q <= load_d; busy_q <= busy_d;
            irq_q <= irq_d; abort_q <= abort_d; cyl_lo_q <= clo_d;
            cyl_hi_q <= chi_d; standby_q <= stby_d; din_ready_q <= drdy_d;
            wr_valid_q <= wrv_d; wr_data_q <= wdat_d;
            dout_valid_q <= dov_d; dout_q <= dout_d;
            smart_en_q <= sen_d; autosave_q <= asv_d; aoff_q <= aoff_d;
            auto_coll_q <= acol_d; nv_wr_q <= nvw_d; save_attr_q <= sav_d;
            offline_go_q <= off_d; flush_req_q <= flr_d; fua_q <= fua_d;
            word_q <= word_d; blk_q <= blk_d; per_q <= per_d;
            left_q <= left_d;
        end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire acc = ce && st_q == ST_IDLE && load_q && cmd_valid;

    status_ok_a: assert property (acc && cmd_code == `CMD_SMART && smart_en_q
        && feat == `SUB_STATUS && !defect_pred |=> cyl_lo_q == `RS_OK_LO
        && cyl_hi_q == `RS_OK_HI) else $error("bad healthy status");
    status_bad_a: assert property (acc && cmd_code == `CMD_SMART && smart_en_q
        && feat == `SUB_STATUS && defect_pred |=> cyl_lo_q == `RS_BAD_LO
        && cyl_hi_q == `RS_BAD_HI) else $error("bad defect status");
    smart_off_a: assert property (acc && cmd_code == `CMD_SMART && !smart_en_q
        && feat != `SUB_ENABLE |=> abort_q && !smart_en_q)
        else $error("disabled smart not aborted");
    enable_keep_a: assert property (acc && cmd_code == `CMD_SMART
        && smart_en_q && feat == `SUB_ENABLE |=> !nv_wr_q && smart_en_q)
        else $error("re-enable changed state");
    disable_stop_a: assert property (ce && !smart_en_q |=> !auto_coll_q)
        else $error("collection runs while disabled");
    auto_on_a: assert property (acc && cmd_code == `CMD_SMART && smart_en_q
        && feat == `SUB_AUTO_OFF && sect_cnt[7:0] == `AUTO_OFF_ON
        |=> ##1 auto_coll_q) else $error("auto offline not on");
    standby_seq_a: assert property (acc && cmd_code == `CMD_STANDBY
        |=> busy_q && standby_q ##1 !busy_q && irq_q)
        else $error("standby sequence wrong");
    stby_imm_a: assert property (acc && cmd_code == `CMD_STBY_IMM
        |=> busy_q ##1 irq_q && standby_q)
        else $error("standby immediate wrong");
    fua_hold_a: assert property (flush_req_q && !flush_done |=> !irq_q)
        else $error("completion before commit");
    irq_busy_a: assert property (st_q == ST_DIN && ce |=> busy_q)
        else $error("busy dropped mid transfer");

    cov_status: cover property (acc && cmd_code == `CMD_SMART
        && feat == `SUB_STATUS ##1 cyl_hi_q == `RS_OK_HI);
    cov_buf: cover property (st_q == ST_DIN && din_valid
        && word_q == `LAST_WORD);
    cov_thr: cover property (st_q == ST_DOUT && word_q == `LAST_WORD);
    cov_flush: cover property (st_q == ST_FLUSH && flush_done);
endmodule : smart_wr_ctrl

/* smart_wr_defines.svh */
// command codes, field values and counts for the write and smart handler
`ifndef SMART_WR_DEFINES_SVH
`define SMART_WR_DEFINES_SVH
`define CMD_SMART      8'hb0
`define SUB_THR_READ   8'hd1
`define SUB_AUTOSAVE   8'hd2
`define SUB_SAVE_ATTR  8'hd3
`define SUB_OFFLINE    8'hd4
`define SUB_ENABLE     8'hd8
`define SUB_DISABLE    8'hd9
`define SUB_STATUS     8'hda
`define SUB_AUTO_OFF   8'hdb
`define CMD_STANDBY    8'he2
`define CMD_STBY_IMM   8'he0
`define CMD_WR_BUF     8'he8
`define CMD_WR_DMA     8'hca
`define CMD_WR_DMA_X   8'h35
`define CMD_WR_DMA_FUA 8'h3d
`define CMD_WR_MUL     8'hc5
`define CMD_WR_MUL_X   8'h39
`define CMD_WR_MUL_FUA 8'hce
`define CMD_WR_SEC     8'h30
`define CMD_WR_SEC_NR  8'h31
`define CMD_WR_SEC_X   8'h34
`define CMD_WR_FPDMA   8'h61
`define RS_OK_LO       8'h4f
`define RS_OK_HI       8'hc2
`define RS_BAD_LO      8'hf4
`define RS_BAD_HI      8'h2c
`define AUTO_OFF_ON    8'hf8
`define AUTO_OFF_OFF   8'h00
`define AUTOSAVE_ON    8'hf1
`define AUTOSAVE_OFF   8'h00
`define WORDS_PER_SEC  9'd256
`define LAST_WORD      8'hff
`define SEC_256        17'd256
`define SEC_65536      17'd65536
`define THR_REV        16'h0001
`define THR_LAST       16'hff00
`endif

/* smart_wr_pkg.sv */
// types shared by the write and smart handler
package smart_wr_pkg;
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_DIN   = 5'b00010,
        ST_DOUT  = 5'b00100,
        ST_FLUSH = 5'b01000,
        ST_DONE  = 5'b10000
    } st_t;
endpackage : smart_wr_pkg
